// >>> verilog/drm_pkg.sv
// constants shared by the data rate measurement block
package drm_pkg;

    // register subaddresses
    localparam logic [2:0] DRM_ADDR_RATIO_HIGH  = 3'h0;
    localparam logic [2:0] DRM_ADDR_RATIO_MID   = 3'h1;
    localparam logic [2:0] DRM_ADDR_RATIO_LOW   = 3'h2;
    localparam logic [2:0] DRM_ADDR_COARSE_UP   = 3'h3;
    localparam logic [2:0] DRM_ADDR_MISC_STATUS = 3'h4;
    localparam logic [2:0] DRM_ADDR_CTRL_A      = 3'h5;
    localparam logic [2:0] DRM_ADDR_CTRL_B      = 3'h6;
    localparam logic [2:0] DRM_ADDR_CTRL_C      = 3'h7;
    localparam logic [7:0] DRM_ADDR_LAST        = 8'h07;

    // control_reg_a fields
    localparam int DRM_A_LOCK_REF_BIT  = 0;
    localparam int DRM_A_FINE_EN_BIT   = 1;
    localparam int DRM_A_RATIO_LSB     = 2;
    localparam int DRM_A_RANGE_LSB     = 6;
    // control_reg_b fields
    localparam int DRM_B_RESTART_BIT   = 3;
    localparam int DRM_B_REACQ_BIT     = 5;
    // misc status fields
    localparam int DRM_M_COARSE_LSB    = 0;
    localparam int DRM_M_COMPLETE_BIT  = 2;
    localparam int DRM_M_UNLOCK_BIT    = 3;

    // reset values
    localparam logic [7:0] DRM_CTRL_A_RST  = 8'h00;
    localparam logic [7:0] DRM_CTRL_B_RST  = 8'h00;
    localparam logic [7:0] DRM_CTRL_C_RST  = 8'h00;

    // reference range select codes
    localparam logic [1:0] DRM_RANGE_12M   = 2'h0;
    localparam logic [1:0] DRM_RANGE_25M   = 2'h1;
    localparam logic [1:0] DRM_RANGE_50M   = 2'h2;
    localparam logic [1:0] DRM_RANGE_100M  = 2'h3;

    // measurement
    localparam int DRM_RATIO_W         = 23;
    localparam int DRM_WIN_BASE_LOG2   = 14;
    localparam int DRM_RESOLUTION_PPM  = 100;

    // serial slave address: msb fixed 1, bit 5 strap, rest zero
    localparam logic [6:0] DRM_SLAVE_BASE  = 7'h40;
    localparam int DRM_SLAVE_STRAP_BIT = 5;

endpackage

// >>> verilog/drm_serial_slave.sv
// two-wire serial register slave with subaddress and autoincrement
`timescale 1ns/100ps
module drm_serial_slave
    import drm_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // serial pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe_n_out,
    input  wire logic       addr_strap_in,
    // register side
    output logic [2:0]      reg_addr_out,
    output logic [7:0]      wr_data_out,
    output logic            wr_strobe_out,
    input  wire logic [7:0] rd_data_in
);

    typedef enum logic [3:0] {
        SS_IDLE, SS_DEV, SS_DEV_ACK, SS_SUB, SS_SUB_ACK,
        SS_WR, SS_WR_ACK, SS_RD, SS_RD_ACK
    } drm_slave_state_t;

    drm_slave_state_t state;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       strap_s1;
    logic       strap_s2;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic [3:0] bitcnt;
    logic       rw;
    logic       master_ack;
    logic [6:0] my_addr;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;

    // two-flop synchronisers; bit 2 only for edge detection
    always_ff @(posedge mclk_in) begin
        scl_s    <= {scl_s[1:0], scl_in};
        sda_s    <= {sda_s[1:0], sda_in};
        strap_s1 <= addr_strap_in;
        strap_s2 <= strap_s1;
    end

    assign scl_rise   = scl_s[1] & ~scl_s[2];
    assign scl_fall   = ~scl_s[1] & scl_s[2];
    assign start_cond = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_cond  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

    always_comb begin
        my_addr = DRM_SLAVE_BASE;
        my_addr[DRM_SLAVE_STRAP_BIT] = strap_s2;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state         <= SS_IDLE;
            shreg         <= 8'h00;
            txreg         <= 8'h00;
            bitcnt        <= 4'h0;
            rw            <= 1'b0;
            master_ack    <= 1'b0;
            sda_oe_n_out  <= 1'b1;
            reg_addr_out  <= 3'h0;
            wr_data_out   <= 8'h00;
            wr_strobe_out <= 1'b0;
        end else begin
            wr_strobe_out <= 1'b0;
            if (start_cond) begin
                state        <= SS_DEV;
                bitcnt       <= 4'h0;
                sda_oe_n_out <= 1'b1;
            end else if (stop_cond) begin
                state        <= SS_IDLE;
                sda_oe_n_out <= 1'b1;
            end else if (scl_rise && state != SS_IDLE) begin
                shreg  <= {shreg[6:0], sda_s[1]};
                bitcnt <= bitcnt + 4'h1;
                if (state == SS_RD_ACK) begin
                    master_ack <= ~sda_s[1];
                    if (!sda_s[1] && reg_addr_out != DRM_ADDR_LAST[2:0])
                        reg_addr_out <= reg_addr_out + 3'h1;
                end
            end else if (scl_fall) begin
                unique case (state)
                    SS_IDLE: ;
                    SS_DEV: if (bitcnt == 4'h8) begin
                        if (shreg[7:1] == my_addr) begin
                            sda_oe_n_out <= 1'b0;
                            rw           <= shreg[0];
                            state        <= SS_DEV_ACK;
                        end else begin
                            state <= SS_IDLE;
                        end
                    end
                    SS_DEV_ACK: begin
                        bitcnt <= 4'h0;
                        if (rw) begin
                            txreg        <= rd_data_in;
                            sda_oe_n_out <= rd_data_in[7];
                            state        <= SS_RD;
                        end else begin
                            sda_oe_n_out <= 1'b1;
                            state        <= SS_SUB;
                        end
                    end
                    SS_SUB: if (bitcnt == 4'h8) begin
                        if (shreg <= DRM_ADDR_LAST) begin
                            reg_addr_out <= shreg[2:0];
                            sda_oe_n_out <= 1'b0;
                            state        <= SS_SUB_ACK;
                        end else begin
                            state <= SS_IDLE;
                        end
                    end
                    SS_SUB_ACK, SS_WR_ACK: begin
                        sda_oe_n_out <= 1'b1;
                        bitcnt       <= 4'h0;
                        state        <= SS_WR;
                        if (state == SS_WR_ACK && reg_addr_out != DRM_ADDR_LAST[2:0])
                            reg_addr_out <= reg_addr_out + 3'h1;
                    end
                    SS_WR: if (bitcnt == 4'h8) begin
                        wr_data_out   <= shreg;
                        wr_strobe_out <= 1'b1;
                        sda_oe_n_out  <= 1'b0;
                        state         <= SS_WR_ACK;
                    end
                    SS_RD: if (bitcnt == 4'h8) begin
                        sda_oe_n_out <= 1'b1;
                        state        <= SS_RD_ACK;
                    end else begin
                        txreg        <= {txreg[6:0], 1'b0};
                        sda_oe_n_out <= txreg[6];
                    end
                    SS_RD_ACK: begin
                        bitcnt <= 4'h0;
                        if (master_ack) begin
                            txreg        <= rd_data_in;
                            sda_oe_n_out <= rd_data_in[7];
                            state        <= SS_RD;
                        end else begin
                            state <= SS_IDLE;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// >>> verilog/drm_top.sv
// data rate measurement: fine ratio against reference, coarse code, restart control
`timescale 1ns/100ps
module drm_top
    import drm_pkg::*;
#(
    parameter int WIN_BASE_LOG2 = DRM_WIN_BASE_LOG2,
    parameter int RATIO_W       = DRM_RATIO_W
) (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // serial register pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n_out,
    input  wire logic       addr_strap_in,
    // clocks being measured
    input  wire logic       reference_clock_in,
    input  wire logic       data_clock_in,
    // recovery core status
    input  wire logic       loss_of_lock_in,
    input  wire logic [8:0] coarse_code_in,
    // recovery core controls
    output logic            lock_to_ref_en_out,
    output logic            fine_measure_en_out,
    output logic [3:0]      ref_ratio_out,
    output logic [1:0]      ref_range_sel_out,
    output logic [7:0]      control_reg_c_out,
    output logic            reacquire_out,
    output logic            measure_complete_out
);

    localparam int WIN_W = WIN_BASE_LOG2 + 4;

    typedef enum logic [2:0] {
        MS_IDLE, MS_ARM, MS_RUN, MS_STOP, MS_DONE
    } drm_meas_state_t;

    // register file
    logic [7:0]         control_reg_a;
    logic [7:0]         control_reg_b;
    logic [7:0]         control_reg_c;
    logic [7:0]         misc_status;
    logic [RATIO_W-1:0] measured_ratio_word;
    logic [8:0]         coarse_code;
    logic               loss_of_lock;
    logic               complete;

    // slave side
    logic [2:0]         reg_addr;
    logic [7:0]         wr_data;
    logic               wr_strobe;
    logic [7:0]         rd_data;

    // control edges
    logic               restart_prev;
    logic               reacq_prev;
    logic               restart_fall;

    // measurement
    drm_meas_state_t    state;
    logic               meas_en;
    logic [WIN_W-1:0]   win_cnt;
    logic [WIN_W-1:0]   win_last;
    logic [2:0]         ref_s;
    logic               ref_edge;
    logic               ack_m1;
    logic               ack_m2;
    logic               clr_ack_m1;
    logic               clr_ack_m2;
    logic               seq_hold;
    logic               win_open;
    logic               win_close;
    logic               win_done;

    // link domain
    logic               rst_d1;
    logic               rst_d2;
    logic               clr_d1;
    logic               clr_d2;
    logic               en_d1;
    logic               en_d2;
    logic [RATIO_W-1:0] data_cnt;

    drm_serial_slave u_slave (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .scl_in        (scl_in),
        .sda_in        (sda_in),
        .sda_oe_n_out  (sda_oe_n_out),
        .addr_strap_in (addr_strap_in),
        .reg_addr_out  (reg_addr),
        .wr_data_out   (wr_data),
        .wr_strobe_out (wr_strobe),
        .rd_data_in    (rd_data)
    );

    // open drain: only ever pulls low
    assign sda_out = 1'b0;

    // ---------------- control registers ----------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            control_reg_a <= DRM_CTRL_A_RST;
            control_reg_b <= DRM_CTRL_B_RST;
            control_reg_c <= DRM_CTRL_C_RST;
        end else if (wr_strobe) begin
            unique case (reg_addr)
                DRM_ADDR_CTRL_A: control_reg_a <= wr_data;
                DRM_ADDR_CTRL_B: control_reg_b <= wr_data;
                DRM_ADDR_CTRL_C: control_reg_c <= wr_data;
                default: ;
            endcase
        end
    end

    // controls go straight to the recovery core; measuring adds nothing
    always_comb begin
        lock_to_ref_en_out  = control_reg_a[DRM_A_LOCK_REF_BIT];
        fine_measure_en_out = control_reg_a[DRM_A_FINE_EN_BIT];
        ref_ratio_out       = control_reg_a[DRM_A_RATIO_LSB +: 4];
        ref_range_sel_out   = control_reg_a[DRM_A_RANGE_LSB +: 2];
        control_reg_c_out   = control_reg_c;
    end

    // restart bit history for its falling edge
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            restart_prev <= 1'b0;
        end else begin
            restart_prev <= control_reg_b[DRM_B_RESTART_BIT];
        end
    end

    // registers untouched, only a one-cycle pulse to the core
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reacq_prev    <= 1'b0;
            reacquire_out <= 1'b0;
        end else begin
            reacq_prev    <= control_reg_b[DRM_B_REACQ_BIT];
            reacquire_out <= reacq_prev & ~control_reg_b[DRM_B_REACQ_BIT];
        end
    end

    assign restart_fall = restart_prev & ~control_reg_b[DRM_B_RESTART_BIT];

    // ---------------- reference edge counting ----------------
    always_ff @(posedge mclk_in) begin
        ref_s      <= {ref_s[1:0], reference_clock_in};
        ack_m1     <= en_d2;
        ack_m2     <= ack_m1;
        clr_ack_m1 <= clr_d2;
        clr_ack_m2 <= clr_ack_m1;
    end

    assign ref_edge = ref_s[1] & ~ref_s[2];

    // window of 2^(base+range) reference periods gives the scaled ratio
    assign win_last = (WIN_W'(1) << (WIN_BASE_LOG2 + int'(ref_range_sel_out))) - WIN_W'(1);

    // ---------------- measurement sequencer ----------------
    // restart high or fine enable low keeps everything idle
    assign seq_hold  = control_reg_b[DRM_B_RESTART_BIT] || !fine_measure_en_out;
    // gate opens and closes on reference edges: whole periods only
    assign win_open  = (state == MS_ARM) && ref_edge && !clr_ack_m2;
    assign win_close = (state == MS_RUN) && ref_edge && (win_cnt == win_last);
    // link counter frozen once the gate echo has dropped
    assign win_done  = (state == MS_STOP) && !ack_m2 && !seq_hold;

    always_ff @(posedge mclk_in) begin
        if (rst_in || seq_hold) begin
            state <= MS_IDLE;
        end else begin
            unique case (state)
                MS_IDLE: if (restart_fall) begin
                    state <= MS_ARM;
                end
                MS_ARM: if (win_open) begin
                    state <= MS_RUN;
                end
                MS_RUN: if (win_close) begin
                    state <= MS_STOP;
                end
                MS_STOP: if (win_done) begin
                    state <= MS_DONE;
                end
                MS_DONE: ;
            endcase
        end
    end

    // gate level handed to the link counter
    always_ff @(posedge mclk_in) begin
        if (rst_in || seq_hold) begin
            meas_en <= 1'b0;
        end else if (win_open) begin
            meas_en <= 1'b1;
        end else if (win_close) begin
            meas_en <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in || seq_hold || win_open) begin
            win_cnt <= '0;
        end else if (state == MS_RUN && ref_edge && !win_close) begin
            win_cnt <= win_cnt + WIN_W'(1);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            complete <= 1'b0;
        end else if (control_reg_b[DRM_B_RESTART_BIT] || restart_fall) begin
            complete <= 1'b0;
        end else if (win_done) begin
            complete <= 1'b1;
        end
    end

    // result captured once the link counter has frozen
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            measured_ratio_word <= '0;
        end else if (win_done) begin
            measured_ratio_word <= data_cnt;
        end
    end

    // ---------------- link clock domain ----------------
    // two-flop crossings of reset, clear level and enable level
    always_ff @(posedge data_clock_in) begin
        rst_d1 <= rst_in;
        rst_d2 <= rst_d1;
        clr_d1 <= control_reg_b[DRM_B_RESTART_BIT];
        clr_d2 <= clr_d1;
        en_d1  <= meas_en;
        en_d2  <= en_d1;
    end

    // count recovered data clocks; saturate rather than wrap
    always_ff @(posedge data_clock_in) begin
        if (rst_d2 || clr_d2) begin
            data_cnt <= '0;
        end else if (en_d2 && data_cnt != {RATIO_W{1'b1}}) begin
            data_cnt <= data_cnt + RATIO_W'(1);
        end
    end

    // ---------------- status capture ----------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            coarse_code <= 9'h000;
        end else begin
            coarse_code <= coarse_code_in;
        end
    end

    // lock counts as lost until the core reports otherwise
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            loss_of_lock <= 1'b1;
        end else begin
            loss_of_lock <= loss_of_lock_in;
        end
    end

    always_comb begin
        misc_status                     = 8'h00;
        misc_status[DRM_M_COARSE_LSB]   = coarse_code[0];
        misc_status[DRM_M_COMPLETE_BIT] = complete;
        misc_status[DRM_M_UNLOCK_BIT]   = loss_of_lock;
    end

    assign measure_complete_out = complete;

    // ---------------- read mux ----------------
    always_comb begin
        unique case (reg_addr)
            DRM_ADDR_RATIO_HIGH:  rd_data = {1'b0, measured_ratio_word[22:16]};
            DRM_ADDR_RATIO_MID:   rd_data = measured_ratio_word[15:8];
            DRM_ADDR_RATIO_LOW:   rd_data = measured_ratio_word[7:0];
            DRM_ADDR_COARSE_UP:   rd_data = coarse_code[8:1];
            DRM_ADDR_MISC_STATUS: rd_data = misc_status;
            DRM_ADDR_CTRL_A:      rd_data = control_reg_a;
            DRM_ADDR_CTRL_B:      rd_data = control_reg_b;
            DRM_ADDR_CTRL_C:      rd_data = control_reg_c;
        endcase
    end

endmodule

// >>> verif/drm_top_asserts.sv
// assertions on the data rate measurement top ports
`timescale 1ns/100ps
module drm_top_asserts
    import drm_pkg::*;
(
    // clock, reset and serial pins
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n_out,
    // control and status outputs
    input wire logic       lock_to_ref_en_out,
    input wire logic       fine_measure_en_out,
    input wire logic [1:0] ref_range_sel_out,
    input wire logic [7:0] control_reg_c_out,
    input wire logic       reacquire_out,
    input wire logic       measure_complete_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_reset_idle: assert property (disable iff (1'b0)
        rst_in |=> sda_oe_n_out && !reacquire_out && !measure_complete_out)
        else $error("outputs not idle after reset");
    a_range_default: assert property (disable iff (1'b0)
        rst_in |=> ref_range_sel_out == DRM_RANGE_12M && !fine_measure_en_out)
        else $error("range select not at default after reset");
    a_reacq_single: assert property (reacquire_out |=> !reacquire_out [*4])
        else $error("reacquire pulse longer than one cycle");
    a_reacq_keeps_ctrl: assert property (reacquire_out |->
        $stable(ref_range_sel_out) && $stable(fine_measure_en_out)
        && $stable(control_reg_c_out))
        else $error("controls changed at reacquire");
    a_done_needs_fine: assert property (
        $rose(measure_complete_out) |-> fine_measure_en_out)
        else $error("complete set without fine enable");
    a_meas_no_lock: assert property ($rose(measure_complete_out) |->
        !reacquire_out && $stable(lock_to_ref_en_out))
        else $error("measurement disturbed lock controls");
    a_range_on_write: assert property ($changed(ref_range_sel_out) |->
        !scl_in && !$past(scl_in, 2))
        else $error("range select changed outside a write");
    a_sda_on_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
        else $error("data line moved while serial clock high");
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("data line value not zero");
endmodule
bind drm_top drm_top_asserts u_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .lock_to_ref_en_out(lock_to_ref_en_out),
    .fine_measure_en_out(fine_measure_en_out), .ref_range_sel_out(ref_range_sel_out),
    .control_reg_c_out(control_reg_c_out), .reacquire_out(reacquire_out),
    .measure_complete_out(measure_complete_out));

// >>> verif/drm_master_model.sv
// two-wire register master model driving the serial pins
`timescale 1ns/100ps
module drm_master_model
#(
    parameter logic [6:0] DEV_ADDR = 7'h60,
    parameter int         HC       = 6
) (
    // clock
    input  wire logic       mclk_in,
    // serial pins
    output logic            scl_out,
    output logic            sda_out,
    input  wire logic       sda_in,
    // read results
    output logic            rd_valid_out,
    output logic [7:0]      rd_byte_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        rd_valid_out = 1'b0;
        rd_byte_out = 8'h00;
    end

    task automatic hc;
        repeat (HC) @(negedge mclk_in);
    endtask

    task automatic start;
        sda_out = 1'b1;
        hc;
        scl_out = 1'b1;
        hc;
        sda_out = 1'b0;
        hc;
        scl_out = 1'b0;
        hc;
    endtask

    task automatic stop;
        sda_out = 1'b0;
        hc;
        scl_out = 1'b1;
        hc;
        sda_out = 1'b1;
        hc;
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= -1; i--) begin
            sda_out = (i < 0) ? last : d[i];
            hc;
            scl_out = 1'b1;
            hc;
            if (i < 0) ack = !sda_in;
            else r[i] = sda_in;
            scl_out = 1'b0;
            hc;
        end
    endtask

    task automatic wr(input logic [7:0] sub, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0, a1, a2;
        start;
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, a0);
        xfer(sub, 1'b1, r, a1);
        xfer(d, 1'b1, r, a2);
        stop;
        ok = a0 && a1 && a2;
    endtask

    // reads n bytes by autoincrement, nack on the last
    task automatic rd(input logic [7:0] sub, input int n, output logic [23:0] v);
        logic [7:0] r;
        logic       a;
        v = 24'h0;
        start;
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
        xfer(sub, 1'b1, r, a);
        start;
        xfer({DEV_ADDR, 1'b1}, 1'b1, r, a);
        for (int k = 0; k < n; k++) begin
            xfer(8'hff, k == n - 1, r, a);
            v = {v[15:0], r};
            rd_byte_out = r;
            rd_valid_out = 1'b1;
            @(negedge mclk_in);
            rd_valid_out = 1'b0;
        end
        stop;
    endtask
endmodule

// >>> verif/drm_top_tb.sv
// self-checking bench for the data rate measurement block
`timescale 1ns/100ps
module drm_top_tb;
    import drm_pkg::*;
    localparam int WIN    = 4;
    localparam int REF_NS = 48;
    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b1;
    logic        ref_clk = 1'b0;
    logic        dat_clk = 1'b0;
    logic        loss_of_lock = 1'b1;
    logic [8:0]  code    = 9'h000;
    logic        scl, m_sda, sda_oe_n, sda_o, rd_valid, ok;
    logic        lock_en, fine_en, reacq, done;
    logic [7:0]  rd_byte, ctrl_c, c, a;
    logic [3:0]  ratio;
    logic [1:0]  range;
    logic [23:0] v;
    logic [15:0] expq[$];
    string       nameq[$];
    int          miscompares = 0;
    int          checks      = 0;
    int          n_reacq     = 0;
    wire         sda = m_sda & (sda_oe_n | sda_o);

    always #2.5 mclk_in = ~mclk_in;
    always #(REF_NS / 2) ref_clk = ~ref_clk;
    initial #1.7 forever #6 dat_clk = ~dat_clk;

    drm_top #(.WIN_BASE_LOG2(WIN)) uut (
        .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
        .sda_oe_n_out(sda_oe_n), .addr_strap_in(1'b1), .reference_clock_in(ref_clk),
        .data_clock_in(dat_clk), .loss_of_lock_in(loss_of_lock), .coarse_code_in(code),
        .lock_to_ref_en_out(lock_en), .fine_measure_en_out(fine_en), .ref_ratio_out(ratio),
        .ref_range_sel_out(range), .control_reg_c_out(ctrl_c), .reacquire_out(reacq),
        .measure_complete_out(done));

    drm_master_model mst (
        .mclk_in(mclk_in), .scl_out(scl), .sda_out(m_sda), .sda_in(sda),
        .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));

    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_byte(input string nm, input logic [15:0] me, input logic [7:0] g);
        checks++;
        if ((g & me[15:8]) !== me[7:0]) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, me[7:0], g);
        end
    endtask

    task automatic cmp_near(input string nm, input int e, input logic [22:0] g);
        checks++;
        if ($isunknown(g) || int'(g) > e + 2 || int'(g) < e - 2) begin
            miscompares++;
            $display("unexpected %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic exp_rd(input string nm, input logic [7:0] m, input logic [7:0] e);
        nameq.push_back(nm);
        expq.push_back({m, e & m});
    endtask

    task automatic wreg(input logic [2:0] adr, input logic [7:0] d);
        mst.wr({5'h0, adr}, d, ok);
        cmp("write ack", 24'h1, 24'(ok));
    endtask

    always @(posedge rd_valid) begin
        cmp_byte(nameq.pop_front(), expq.pop_front(), rd_byte);
    end

    always @(posedge mclk_in) begin
        if (reacq === 1'b1) n_reacq++;
    end

    initial begin
        void'($urandom(32'h1704));
        repeat (20) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        code = 9'($urandom);
        loss_of_lock = 1'($urandom);
        cmp("range select", 24'(DRM_RANGE_12M), 24'(range));
        exp_rd("coarse upper", 8'hff, code[8:1]);
        exp_rd("misc status", 8'h0d, {4'h0, loss_of_lock, 2'b00, code[0]});
        for (int k = 0; k < 4; k++) exp_rd("control reset", 8'hff, 8'h00);
        mst.rd({5'h0, DRM_ADDR_COARSE_UP}, 6, v);
        mst.wr(8'h09, 8'h55, ok);
        cmp("bad subaddress ack", 24'h0, 24'(ok));
        c = 8'($urandom);
        wreg(DRM_ADDR_CTRL_C, c);
        loss_of_lock = 1'b0;
        for (int r = 0; r < 4; r++) begin
            a = {2'(r), 4'($urandom), 2'b10};
            wreg(DRM_ADDR_CTRL_A, a);
            cmp("range select", 24'(r), 24'(range));
            cmp("fine enable", 24'h1, 24'(fine_en));
            cmp("ref ratio", 24'(a[5:2]), 24'(ratio));
            cmp("lock enable", 24'h0, 24'(lock_en));
            wreg(DRM_ADDR_CTRL_B, 8'h08);
            cmp("complete under restart", 24'h0, 24'(done));
            wreg(DRM_ADDR_CTRL_B, 8'h00);
            for (int t = 0; t < 5000 && done !== 1'b1; t++) @(negedge mclk_in);
            cmp("complete", 24'h1, 24'(done));
            exp_rd("misc status", 8'h0d, {4'h0, loss_of_lock, 1'b1, 1'b0, code[0]});
            exp_rd("ratio high", 8'hff, 8'h00);
            exp_rd("ratio mid", 8'hfc, 8'h00);
            exp_rd("ratio low", 8'h00, 8'h00);
            mst.rd({5'h0, DRM_ADDR_MISC_STATUS}, 1, v);
            mst.rd({5'h0, DRM_ADDR_RATIO_HIGH}, 3, v);
            cmp_near("ratio", (1 << (WIN + r)) * REF_NS / 12, v[22:0]);
        end
        wreg(DRM_ADDR_CTRL_B, 8'h20);
        wreg(DRM_ADDR_CTRL_B, 8'h00);
        repeat (4) @(negedge mclk_in);
        cmp("reacquire pulses", 24'h1, 24'(n_reacq));
        cmp("range kept", 24'h3, 24'(range));
        cmp("control c kept", 24'(c), 24'(ctrl_c));
        results;
    end

    initial begin
        #300000;
        miscompares++;
        results;
    end

    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
endmodule
